// ===== hostport_dev.sv
// Purpose: device end of the dual-mode host bus port
// Assumes: one clock; strap mode stable through reset
// Notes: isa memory window decoded from the latched upper bits; i/o window from the synced address
// Summary of operation
// R1: shared pins follow strapped bus mode
// R2: isa i/o hit drives io16 low
// R3: isa display memory hit drives mem16 low
// R4: local mode may assert backoff to processor
// R5: local mode uses 32-bit data path
// R6: host enables upper byte in isa
// R7: local reset clears port, aligns half clock
// R8: later boards ground local reset
// R9: isa upper address latched at ale fall
// R10: ads low starts a local cycle
// R11: irq rises at display end when enabled
// R12: only clear write removes irq
// R13: wait states on display memory only
// R14: unselected mode pins stay undriven
`timescale 1ns/1ns
module hostport_dev
  import hostport_pkg::*;
#(
  parameter int MEM_WAIT = MEM_WAIT_CYC, // isa memory wait cycles
  parameter int LOC_WAIT = LOC_WAIT_CYC // local cycle wait cycles
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // bus pins
  hostport_if.dev bus,
  // strap
  input wire logic bus_mode_in,
  // internal access port
  output logic req_out,
  output logic req_wr_out,
  output logic req_mem_out,
  output logic [31:0] req_addr_out,
  output logic [31:0] req_wdata_out,
  output logic [3:0] req_be_out,
  input wire logic [31:0] rdata_in,
  // display events, retrace end register and backoff request
  input wire logic vde_in,
  input wire logic retrace_wr_in,
  input wire logic [7:0] retrace_data_in,
  input wire logic backoff_req_in,
  // status
  output logic irq_pend_out,
  output hostport_pkg::bus_mode_t mode_out,
  output logic local_reset_out
);
  import hostport_pkg::*;
  initial begin
    if (MEM_WAIT < 1 || MEM_WAIT > 255 || LOC_WAIT < 1 || LOC_WAIT > 255) begin
      $error("wait counts must lie in 1..255");
    end
  end
  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range
  // ==========================================================
  // pin synchronisers, two stages before any use
  // ==========================================================
  localparam int SW = 74;
  logic [SW-1:0] sa_q, sb_q;
  logic [31:0] a_s;
  logic cmd_n_s, mio_s, wr_s, p73_s, p74_s, p72_s, p75_s, strap_s;
  logic [3:0] be_n_s;
  logic [29:0] dat_s;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sa_q <= '1;
      sb_q <= '1;
    end else begin
      sa_q <= {bus.addr, bus.cmd_n, bus.mio, bus.wr, bus.be_n, bus.p73, bus.p74,
        bus.p72, bus.p75, bus.dat, bus_mode_in};
      sb_q <= sa_q;
    end
  end
  assign {a_s, cmd_n_s, mio_s, wr_s, be_n_s, p73_s, p74_s, p72_s, p75_s, dat_s, strap_s} = sb_q;
  // ==========================================================
  // mode strap, caught after reset release
  // ==========================================================
  logic [1:0] boot_q;
  bus_mode_t mode_q;
  logic booted, isa, loc;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_q <= 2'h0;
      mode_q <= MODE_ISA;
    end else if (boot_q != BOOT_DONE) begin
      boot_q <= boot_q + 2'h1;
      if (boot_q == BOOT_DONE - 2'h1) begin
        mode_q <= strap_s ? MODE_LOC : MODE_ISA; // R1
      end
    end
  end
  assign booted = (boot_q == BOOT_DONE);
  assign isa = booted && (mode_q == MODE_ISA); // R1
  assign loc = booted && (mode_q == MODE_LOC); // R1
  // ==========================================================
  // local reset and half-rate working clock phase
  // ==========================================================
  logic lrst, phase_q;
  assign lrst = loc && p73_s;
  // phase held low in local reset so all parts align
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_q <= 1'b0;
    end else if (lrst) begin
      phase_q <= 1'b0; // R7
    end else begin
      phase_q <= ~phase_q;
    end
  end
  // ==========================================================
  // isa address latch and decode
  // ==========================================================
  logic [6:0] la_q; // upper latchable bits 23:17
  logic [31:0] isa_addr, dec_addr;
  logic cmd_prev_q, cmd_start, mem_hit, io_hit;
  // transparent while ale high, holds from its falling edge
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      la_q <= LATCH_RST;
      cmd_prev_q <= 1'b1;
    end else begin
      if (p74_s) begin
        la_q <= a_s[23:17]; // R9
      end
      cmd_prev_q <= cmd_n_s;
    end
  end
  assign isa_addr = {a_s[31:24], p74_s ? a_s[23:17] : la_q, a_s[16:0]}; // R9
  assign dec_addr = isa ? isa_addr : a_s;
  assign cmd_start = !cmd_n_s && cmd_prev_q;
  // rom window excluded so it never sees wait states
  assign mem_hit = mio_s && in_range(dec_addr, VGA_MEM_BASE, VGA_MEM_LAST)
    && !in_range(dec_addr, ROM_BASE, ROM_LAST); // R13
  assign io_hit = !mio_s && in_range(a_s, IO_BASE, IO_LAST);
  // ==========================================================
  // cycle state machine
  // ==========================================================
  typedef enum logic [2:0] {S_IDLE, S_IWAIT, S_IREQ, S_IHOLD, S_LWAIT, S_LREQ, S_LACK} state_t;
  state_t st_q, st_d;
  logic [7:0] cnt_q;
  logic backoff_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (isa && cmd_start && mem_hit) begin
          st_d = S_IWAIT; // R13
        end else if (isa && cmd_start && io_hit) begin
          st_d = S_IREQ; // no wait on i/o
        end else if (loc && phase_q && !p74_s && (mem_hit || io_hit)) begin
          st_d = S_LWAIT; // R10
        end
      end
      S_IWAIT: if (cnt_q == 8'h00) st_d = S_IREQ;
      S_IREQ: st_d = S_IHOLD;
      S_IHOLD: if (cmd_n_s) st_d = S_IDLE;
      S_LWAIT: begin
        if (backoff_q) begin
          st_d = S_IDLE; // R4
        end else if (cnt_q == 8'h00) begin
          st_d = S_LREQ;
        end
      end
      S_LREQ: st_d = S_LACK;
      S_LACK: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    if (lrst) begin
      st_d = S_IDLE; // R7
    end
  end
  // state and wait counter
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= S_IDLE;
      cnt_q <= 8'h00;
      backoff_q <= 1'b0;
    end else begin
      st_q <= st_d;
      backoff_q <= loc && backoff_req_in; // R4
      if (st_q == S_IDLE) begin
        cnt_q <= isa ? 8'(MEM_WAIT - 1) : 8'(LOC_WAIT - 1);
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // ==========================================================
  // internal access port
  // ==========================================================
  logic [31:0] rd_q;
  logic go_req;
  assign go_req = (st_d == S_IREQ) || (st_d == S_LREQ);
  // attributes taken with the request; read data one edge later
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_out <= 1'b0;
      req_wr_out <= 1'b0;
      req_mem_out <= 1'b0;
      req_addr_out <= 32'h0000_0000;
      req_wdata_out <= 32'h0000_0000;
      req_be_out <= 4'h0;
      rd_q <= 32'h0000_0000;
    end else begin
      req_out <= go_req;
      if (go_req) begin
        req_wr_out <= wr_s;
        req_mem_out <= mio_s;
        req_addr_out <= dec_addr;
        if (isa) begin
          req_wdata_out <= {16'h0000, dat_s[15:0]};
          req_be_out <= {2'b00, !p73_s, !a_s[0]}; // R6
        end else begin
          req_wdata_out <= {p72_s, p75_s, dat_s}; // R5
          req_be_out <= ~be_n_s;
        end
      end
      if (st_q == S_IREQ || st_q == S_LREQ) begin
        rd_q <= rdata_in;
      end
    end
  end
  // ==========================================================
  // vertical display end interrupt
  // ==========================================================
  logic [7:0] retrace_end_reg_q;
  logic irq_q, vde_prev_q, irq_set, irq_clr;
  assign irq_set = vde_in && !vde_prev_q && retrace_end_reg_q[IRQ_EN_BIT]; // R11
  assign irq_clr = retrace_wr_in && !retrace_data_in[IRQ_CLR_BIT]; // R12
  // set beats a same-cycle clear so no display end is lost
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      retrace_end_reg_q <= RETRACE_RST;
      vde_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      vde_prev_q <= vde_in;
      if (retrace_wr_in) begin
        retrace_end_reg_q <= retrace_data_in;
      end
      if (irq_set) begin
        irq_q <= 1'b1; // R11
      end else if (irq_clr) begin
        irq_q <= 1'b0; // R12
      end
    end
  end
  // ==========================================================
  // pin drivers and status, all from flops
  // ==========================================================
  logic rd_drive;
  assign rd_drive = !wr_s && ((st_d == S_IHOLD) || (st_d == S_LACK));
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus.p71_d <= 1'b1;
      bus.p71_oe <= 1'b0;
      bus.p72_dd <= 1'b1;
      bus.p72_doe <= 1'b0;
      bus.p75_dd <= 1'b0;
      bus.p75_doe <= 1'b0;
      bus.p77_d <= 1'b1;
      bus.p77_oe <= 1'b0;
      bus.lrdy_d <= 1'b1;
      bus.lrdy_oe <= 1'b0;
      bus.dat_dd <= '1;
      bus.dat_doe <= 1'b0;
      irq_pend_out <= 1'b0;
      mode_out <= MODE_ISA;
      local_reset_out <= 1'b0;
    end else begin
      irq_pend_out <= irq_q;
      mode_out <= mode_q;
      local_reset_out <= lrst;
      // pin 71: io16 in isa, backoff in local; open-drain style
      bus.p71_d <= 1'b0;
      bus.p71_oe <= (isa && io_hit) || (loc && backoff_q); // R2 R4 R14
      // pin 72: mem16 in isa, top data bit in local
      bus.p72_dd <= isa ? 1'b0 : rdata_in[31];
      bus.p72_doe <= (isa && mem_hit) || (loc && rd_drive); // R3 R5 R14
      // pin 75: irq in isa, second data bit in local
      bus.p75_dd <= isa ? irq_q : rdata_in[30];
      bus.p75_doe <= isa || (loc && rd_drive); // R5 R14
      // wait states only while a display memory cycle is held
      bus.p77_d <= 1'b0;
      bus.p77_oe <= isa && (st_d == S_IWAIT); // R13
      bus.lrdy_d <= 1'b0;
      bus.lrdy_oe <= loc && (st_d == S_LACK);
      bus.dat_dd <= isa ? {14'h3FFF, rd_q[15:0]} : rdata_in[29:0];
      bus.dat_doe <= rd_drive; // R5
    end
  end
endmodule : hostport_dev

// ===== hostport_pkg.sv
// Purpose: shared constants and types for the dual-mode host bus port
// Assumes: one 100 MHz clock on both ends
// Notes: address windows and wait counts are plain defaults
package hostport_pkg;
  // ==========================================================
  // bus mode and clock
  // ==========================================================
  typedef enum logic {MODE_ISA, MODE_LOC} bus_mode_t; // strap selects the pin functions
  localparam int CLK_NS = 10; // mclk_in period
  // ==========================================================
  // address windows
  // ==========================================================
  localparam logic [31:0] VGA_MEM_BASE = 32'h000A_0000; // display memory window
  localparam logic [31:0] VGA_MEM_LAST = 32'h000B_FFFF;
  localparam logic [31:0] ROM_BASE = 32'h000C_0000; // bios rom, never waited
  localparam logic [31:0] ROM_LAST = 32'h000C_7FFF;
  localparam logic [31:0] IO_BASE = 32'h0000_03C0; // register i/o window
  localparam logic [31:0] IO_LAST = 32'h0000_03DF;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int MEM_WAIT_NS = 60; // least isa memory wait
  localparam int MEM_WAIT_CYC = (MEM_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOC_WAIT_NS = 40; // least local cycle length
  localparam int LOC_WAIT_CYC = (LOC_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_ISA_MIN = 10; // host strobe before ready is trusted
  localparam int HOST_GAP = 4; // host idle gap between cycles
  localparam int HOST_SETTLE = 3; // host edges for read data to cross the sync
  localparam int ADS_HOLD = 2; // ads held two edges so a half-rate tick sees it
  localparam logic [1:0] BOOT_DONE = 2'h3; // strap caught on the edge before this
  // ==========================================================
  // retrace end register fields and reset values
  // ==========================================================
  localparam int IRQ_EN_BIT = 5;
  localparam int IRQ_CLR_BIT = 4;
  localparam logic [7:0] RETRACE_RST = 8'h00;
  localparam logic [6:0] LATCH_RST = 7'h00;
endpackage : hostport_pkg

// ===== hostport_if.sv
// Purpose: shared host pins between the port and the system bus end
// Assumes: undriven lines float high through pull-ups
// Notes: shared pins resolved from each end's drive
`timescale 1ns/1ns
interface hostport_if;
  // ==========================================================
  // host driven lines
  // ==========================================================
  logic [31:0] addr; // address
  logic cmd_n; // isa command strobe, active low
  logic mio; // 1 = memory, 0 = i/o
  logic wr; // 1 = write
  logic [3:0] be_n; // local byte enables
  logic p73; // isa high byte enable_n or local reset
  logic p74; // isa address latch enable or local ads_n
  // ==========================================================
  // shared lines: device and host drive and enable
  // ==========================================================
  logic p71_d, p71_oe; // io16_n or backoff_n
  logic p72_dd, p72_doe, p72_hd, p72_hoe; // mem16_n or local_data_top_bit
  logic p75_dd, p75_doe, p75_hd, p75_hoe; // irq or local_data_second_bit
  logic p77_d, p77_oe; // channel_ready_out
  logic lrdy_d, lrdy_oe; // local ready_n
  logic [29:0] dat_dd, dat_hd; // low data lines
  logic dat_doe, dat_hoe;
  // ==========================================================
  // resolved levels
  // ==========================================================
  logic p71, p72, p75, p77, lrdy_n;
  logic [29:0] dat;
  assign p71 = p71_oe ? p71_d : 1'b1;
  assign p72 = p72_doe ? p72_dd : (p72_hoe ? p72_hd : 1'b1);
  assign p75 = p75_doe ? p75_dd : (p75_hoe ? p75_hd : 1'b1);
  assign p77 = p77_oe ? p77_d : 1'b1;
  assign lrdy_n = lrdy_oe ? lrdy_d : 1'b1;
  assign dat = dat_doe ? dat_dd : (dat_hoe ? dat_hd : '1);
  modport dev (input addr, cmd_n, mio, wr, be_n, p73, p74, p72, p75, dat,
    output p71_d, p71_oe, p72_dd, p72_doe, p75_dd, p75_doe, p77_d, p77_oe,
    lrdy_d, lrdy_oe, dat_dd, dat_doe);
  modport host (output addr, cmd_n, mio, wr, be_n, p73, p74, p72_hd, p72_hoe,
    p75_hd, p75_hoe, dat_hd, dat_hoe,
    input p71, p72, p75, p77, lrdy_n, dat);
endinterface : hostport_if

// ===== hostport_host.sv
// Purpose: system bus end, runs one isa or local cycle per request
// Assumes: device end on the same interface, same clock
// Notes: one cycle outstanding at a time; busy_out gates requests
`timescale 1ns/1ns
module hostport_host
  import hostport_pkg::*;
#(
  parameter bit HOLD_LRESET_LOW = 1'b1 // later processor boards ground local reset
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // bus pins
  hostport_if.host bus,
  // user side
  input wire hostport_pkg::bus_mode_t bus_mode_in,
  input wire logic local_reset_in,
  input wire logic req_in,
  input wire logic req_mem_in,
  input wire logic req_wr_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic [3:0] req_be_in,
  output logic busy_out,
  output logic done_out,
  output logic abort_out,
  output logic [31:0] rdata_out,
  output logic wide_out,
  output logic irq_out
);
  import hostport_pkg::*;
  // ==========================================================
  // pin synchronisers, two stages before any use
  // ==========================================================
  logic [34:0] sa_q, sb_q;
  logic p71_s, p72_s, p75_s, p77_s, lrdy_s;
  logic [29:0] dat_s;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sa_q <= '1;
      sb_q <= '1;
    end else begin
      sa_q <= {bus.p71, bus.p72, bus.p75, bus.p77, bus.lrdy_n, bus.dat};
      sb_q <= sa_q;
    end
  end
  assign {p71_s, p72_s, p75_s, p77_s, lrdy_s, dat_s} = sb_q;
  // ==========================================================
  // cycle sequencer
  // ==========================================================
  typedef enum logic [2:0] {H_IDLE, H_ISA, H_LADS, H_LWAIT, H_GAP} hstate_t;
  hstate_t st_q, st_d;
  logic [7:0] cnt_q;
  logic isa_q; // mode of the cycle in flight
  logic done_d, abort_d;
  // next state; isa waits the least strobe then for ready released
  always_comb begin
    st_d = st_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        if (req_in) begin
          st_d = (bus_mode_in == MODE_ISA) ? H_ISA : H_LADS; // R1
        end
      end
      H_ISA: begin
        if (cnt_q == 8'h00 && p77_s) begin
          st_d = H_GAP;
          done_d = 1'b1;
        end
      end
      H_LADS: begin
        if (cnt_q == 8'h00) begin
          st_d = H_LWAIT;
        end
      end
      H_LWAIT: begin
        if (!p71_s) begin // R4
          st_d = H_GAP;
          abort_d = 1'b1;
        end else if (!lrdy_s) begin
          st_d = H_GAP;
          done_d = 1'b1;
        end
      end
      H_GAP: begin
        if (cnt_q == 8'h00) begin
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end
  // state, counter and user status
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= H_IDLE;
      cnt_q <= 8'h00;
      isa_q <= 1'b1;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      abort_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      wide_out <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_out <= (st_d != H_IDLE);
      done_out <= done_d;
      abort_out <= abort_d;
      if (st_q == H_IDLE) begin
        isa_q <= (bus_mode_in == MODE_ISA);
        cnt_q <= (bus_mode_in == MODE_ISA) ? 8'(HOST_ISA_MIN - 1) : 8'(ADS_HOLD - 1);
      end else if (st_d == H_GAP && st_q != H_GAP) begin
        cnt_q <= 8'(HOST_GAP - 1);
      end else if (st_q == H_ISA && !p77_s && cnt_q < 8'(HOST_SETTLE)) begin
        cnt_q <= 8'(HOST_SETTLE); // read data lags ready through the sync
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      if (st_q == H_ISA && cnt_q <= 8'(HOST_ISA_MIN - 7) && (!p71_s || !p72_s)) begin
        wide_out <= 1'b1; // past the sync lag, so not the previous cycle's answer
      end else if (st_q == H_IDLE && req_in) begin
        wide_out <= 1'b0;
      end
      if (done_d) begin
        rdata_out <= isa_q ? {16'h0000, dat_s[15:0]} : {p72_s, p75_s, dat_s};
      end
    end
  end
  // irq pin means irq only in isa mode
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (bus_mode_in == MODE_ISA) && p75_s;
    end
  end
  // ==========================================================
  // pin drivers, all from flops
  // ==========================================================
  logic act_d, drv_d;
  assign act_d = (st_d == H_ISA) || (st_d == H_LADS) || (st_d == H_LWAIT);
  assign drv_d = act_d && bus.wr && (st_q != H_IDLE);
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus.addr <= 32'h0000_0000;
      bus.cmd_n <= 1'b1;
      bus.mio <= 1'b0;
      bus.wr <= 1'b0;
      bus.be_n <= 4'hF;
      bus.p73 <= 1'b0;
      bus.p74 <= 1'b1;
      bus.p72_hd <= 1'b1;
      bus.p72_hoe <= 1'b0;
      bus.p75_hd <= 1'b1;
      bus.p75_hoe <= 1'b0;
      bus.dat_hd <= '1;
      bus.dat_hoe <= 1'b0;
    end else begin
      if (st_q == H_IDLE && req_in) begin
        bus.addr <= req_addr_in;
        bus.mio <= req_mem_in;
        bus.wr <= req_wr_in;
        bus.be_n <= ~req_be_in;
        bus.dat_hd <= req_wdata_in[29:0];
        bus.p72_hd <= req_wdata_in[31];
        bus.p75_hd <= req_wdata_in[30];
      end
      bus.cmd_n <= !(st_d == H_ISA);
      if (bus_mode_in == MODE_ISA) begin // R1
        bus.p73 <= !(act_d && req_be_in[1]); // R6
        bus.p74 <= 1'b1; // R9
      end else begin
        bus.p73 <= HOLD_LRESET_LOW ? 1'b0 : local_reset_in; // R8
        bus.p74 <= !(st_d == H_LADS); // R10
      end
      // upper lines only ever driven in local mode
      bus.p72_hoe <= drv_d && !isa_q; // R5 R14
      bus.p75_hoe <= drv_d && !isa_q; // R5 R14
      bus.dat_hoe <= drv_d;
    end
  end
endmodule : hostport_host

// ===== hostport_assertions.sv
// Purpose: interface checks for both ends of the host bus port
// Assumes: one clock, reset low active
// Notes: mode_out tells which pin set is live
`timescale 1ns/1ns
module hostport_assertions
  import hostport_pkg::*;
#(
  parameter int MEM_WAIT = MEM_WAIT_CYC // isa memory wait cycles
) (
  // clock, reset, strap
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire hostport_pkg::bus_mode_t mode_out,
  // host lines
  input wire logic [31:0] addr,
  input wire logic cmd_n,
  input wire logic mio,
  input wire logic wr,
  input wire logic p74,
  // device lines
  input wire logic p71,
  input wire logic p72,
  input wire logic p77,
  input wire logic lrdy_n,
  input wire logic p77_oe,
  input wire logic lrdy_oe,
  input wire logic p72_doe,
  input wire logic p75_doe,
  input wire logic dat_doe
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ======
  // decode
  logic isa; // isa pin set live
  logic io_hit; // i/o window
  logic mem_hit; // display memory window, rom excluded
  logic [7:0] wcnt_q; // cycles the current wait has lasted
  assign isa = mode_out == MODE_ISA;
  assign io_hit = !mio && addr >= IO_BASE && addr <= IO_LAST;
  assign mem_hit = mio && addr >= VGA_MEM_BASE && addr <= VGA_MEM_LAST;
  // low cycles of channel ready; wraps on long waits
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wcnt_q <= 8'h00;
    end else begin
      wcnt_q <= p77 ? 8'h00 : wcnt_q + 8'h01;
    end
  end
  // ======
  // assertions
  io_wide_a: assert property (isa && !cmd_n && io_hit |-> ##[0:5] !p71)
    else $error("io16 missing");
  mem_wide_a: assert property (isa && !cmd_n && mem_hit |-> ##[0:5] !p72)
    else $error("mem16 missing");
  wait_mem_only_a: assert property (!p77 |-> isa && mem_hit)
    else $error("wait outside display memory");
  wait_len_a: assert property ($rose(p77) |-> wcnt_q >= 8'(MEM_WAIT) && wcnt_q <= 8'(MEM_WAIT + 1))
    else $error("wait length wrong");
  ready_pulse_a: assert property (!lrdy_n |=> lrdy_n)
    else $error("local ready longer than one cycle");
  read_wide_a: assert property (!lrdy_n |-> dat_doe == !wr && p72_doe == !wr && p75_doe == !wr)
    else $error("local data path not full width");
  ads_start_a: assert property (!isa && $fell(p74) && mem_hit |-> ##[1:20] (!lrdy_n || !p71))
    else $error("local cycle not answered");
  isa_quiet_a: assert property (isa |-> !lrdy_oe)
    else $error("local ready driven in isa mode");
  loc_quiet_a: assert property (!isa |-> !p77_oe)
    else $error("channel ready driven in local mode");
  cover property (!p77);
  cover property (!lrdy_n && !wr);
  cover property (!isa && !p71);
endmodule : hostport_assertions

// ===== tb_dual_mode_host_bus_port.sv
// Purpose: bench joining host end and device end of the port
// Assumes: 100 MHz mclk_in, reset low for 8 cycles
// Notes: isa mode first, then local mode after a second reset
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_dual_mode_host_bus_port;
  import hostport_pkg::*;
  // ======
  // stimulus and observed signals
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  bus_mode_t mode = MODE_ISA; // strap for both ends
  logic lrst = 1'b0, req = 1'b0, rmem = 1'b0, rwr = 1'b0, vde = 1'b0, rwe = 1'b0, boff = 1'b0;
  logic [31:0] raddr = '0, wdat = '0, rdin = '0;
  logic [3:0] rbe = 4'h0;
  logic [7:0] rdat8 = 8'h00;
  logic busy, done, abrt, wide, irq, dreq, dwr, dmem, pend, lres, ab;
  logic [31:0] rdata, daddr, dwdat;
  logic [3:0] dbe;
  bus_mode_t dmode;
  int err_total = 0, checks = 0, nreq = 0, n0 = 0;
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (dreq === 1'b1) nreq++;
  hostport_if hostport_if_i ();
  hostport_host #(.HOLD_LRESET_LOW(1'b0)) hostport_host_i (.mclk_in, .rstn_in,
    .bus(hostport_if_i), .bus_mode_in(mode), .local_reset_in(lrst), .req_in(req), .req_mem_in(rmem),
    .req_wr_in(rwr), .req_addr_in(raddr), .req_wdata_in(wdat), .req_be_in(rbe), .busy_out(busy),
    .done_out(done), .abort_out(abrt), .rdata_out(rdata), .wide_out(wide), .irq_out(irq));
  hostport_dev hostport_dev_i (.mclk_in, .rstn_in, .bus(hostport_if_i),
    .bus_mode_in(logic'(mode)), .req_out(dreq), .req_wr_out(dwr), .req_mem_out(dmem), .req_addr_out(daddr),
    .req_wdata_out(dwdat), .req_be_out(dbe), .rdata_in(rdin), .vde_in(vde), .retrace_wr_in(rwe),
    .retrace_data_in(rdat8), .backoff_req_in(boff), .irq_pend_out(pend), .mode_out(dmode),
    .local_reset_out(lres));
  hostport_assertions hostport_assertions_i (.mclk_in, .rstn_in, .mode_out(dmode),
    .addr(hostport_if_i.addr), .cmd_n(hostport_if_i.cmd_n), .mio(hostport_if_i.mio), .wr(hostport_if_i.wr),
    .p74(hostport_if_i.p74), .p71(hostport_if_i.p71), .p72(hostport_if_i.p72), .p77(hostport_if_i.p77),
    .lrdy_n(hostport_if_i.lrdy_n), .p77_oe(hostport_if_i.p77_oe), .lrdy_oe(hostport_if_i.lrdy_oe),
    .p72_doe(hostport_if_i.p72_doe), .p75_doe(hostport_if_i.p75_doe), .dat_doe(hostport_if_i.dat_doe));
  // ======
  // tasks
  // reset with a new strap held through boot
  task automatic boot(input bus_mode_t m);
    rstn_in <= 1'b0;
    mode <= m;
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
  endtask : boot
  // one host cycle, then the idle gap
  task automatic xfer(input logic m, w, input logic [31:0] a, d, r, input logic [3:0] b);
    int n = 0;
    rmem <= m;
    rwr <= w;
    raddr <= a;
    wdat <= d;
    rdin <= r;
    rbe <= b;
    req <= 1'b1;
    @(posedge mclk_in);
    req <= 1'b0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (done !== 1'b1 && abrt !== 1'b1 && n < 300);
    ab = abrt;
    if (n >= 300) err_total++;
    repeat (HOST_GAP + 2) @(posedge mclk_in);
  endtask : xfer
  // retrace end register write, then an optional end of display
  task automatic ret_ev(input logic [7:0] v, input logic e);
    rwe <= 1'b1;
    rdat8 <= v;
    @(posedge mclk_in);
    rwe <= 1'b0;
    vde <= e;
    repeat (5) @(posedge mclk_in);
    vde <= 1'b0;
    repeat (5) @(posedge mclk_in);
  endtask : ret_ev
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // ======
  // watchdog: 20000 cycles, well above the whole run
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  // ======
  // tests
  initial begin
    boot(MODE_ISA);
    `CHK(dmode, MODE_ISA)
    xfer(1'b1, 1'b1, 32'h000A_0010, 32'h0000_5A5A, 32'h0, 4'h3);
    `CHK({dwr, dmem, daddr, dwdat[15:0], dbe, wide}, {2'h3, 32'h000A_0010, 16'h5A5A, 4'h3, 1'b1})
    xfer(1'b1, 1'b0, 32'h000B_0000, 32'h0, 32'h1234_BEEF, 4'h1);
    `CHK({rdata[15:0], dbe}, {16'hBEEF, 4'h1})
    xfer(1'b0, 1'b0, 32'h0000_03C4, 32'h0, 32'h0000_00A7, 4'h1);
    `CHK({wide, dmem, rdata[7:0]}, {2'b10, 8'hA7})
    n0 = nreq;
    // rom: no answer, lines float high
    xfer(1'b1, 1'b0, ROM_BASE, 32'h0, 32'h0, 4'h3);
    `CHK({nreq - n0, wide, rdata[15:0]}, {32'd0, 1'b0, 16'hFFFF})
    ret_ev(8'h20, 1'b1);
    `CHK({pend, irq}, 2'b11)
    ret_ev(8'h30, 1'b0);
    `CHK({pend, irq}, 2'b11)
    ret_ev(8'h00, 1'b0);
    `CHK({pend, irq}, 2'b00)
    ret_ev(8'h00, 1'b1);
    `CHK({pend, irq}, 2'b00)
    boot(MODE_LOC);
    `CHK(dmode, MODE_LOC)
    xfer(1'b1, 1'b1, 32'h000A_0100, 32'hC3A5_5A3C, 32'h0, 4'hF);
    `CHK({daddr, dwdat, dbe}, {32'h000A_0100, 32'hC3A5_5A3C, 4'hF})
    xfer(1'b1, 1'b0, 32'h000A_0104, 32'h0, 32'h8E71_F00D, 4'h6);
    `CHK({rdata, dbe}, {32'h8E71_F00D, 4'h6})
    n0 = nreq;
    boff <= 1'b1;
    xfer(1'b1, 1'b0, 32'h000A_0200, 32'h0, 32'h0, 4'hF);
    boff <= 1'b0;
    `CHK({ab, nreq - n0}, {1'b1, 32'd0})
    lrst <= 1'b1;
    repeat (5) @(posedge mclk_in);
    `CHK(lres, 1'b1)
    lrst <= 1'b0;
    repeat (5) @(posedge mclk_in);
    xfer(1'b0, 1'b0, 32'h0000_03C8, 32'h0, 32'h5555_AAAA, 4'hF);
    `CHK({lres, dmem, rdata}, {2'b00, 32'h5555_AAAA})
    print_verdict();
  end
endmodule : tb_dual_mode_host_bus_port
